// ### pkg/panel_pkg.sv
// Shared constants for the drive front-panel logic: timing, codes, symbols.
// Assumes a 10 MHz system clock and a five-digit display with per-digit points.
//
// Contract
// RULE1 - Monitored quantity chosen by monitor_item_select, written or stepped by UP/DOWN.
// RULE2 - Code 15 shows load-to-motor inertia ratio as integer tenths.
// RULE3 - Code 17 puts first resonance low half, second resonance high half.
// RULE4 - Code 18 shows position from index pulse, clamped to plus/minus 5000.
// RULE5 - 16-bit decimal fills five digits with zeros; hex shows four digits.
// RULE6 - 32-bit decimal: high view with point marker, low view lowest five digits.
// RULE7 - 32-bit hex: 'h' prefixes upper four digits, 'L' the lower four.
// RULE8 - Negative decimal shows magnitude with two leftmost points lit; hex never negative.
// RULE9 - Monitor values are 32 bits; halves and radix free; parameters fixed format.
// RULE10 - SET on a selected fault history entry shows its stored fault code.
// RULE11 - SET enters editable jog speed, default 20; UP/DOWN adjust, SHIFT moves cursor.
// RULE12 - SET confirms jog; rotation commanded only while UP or DOWN held.
// RULE13 - MODE in jog returns to jog entry; SET then edits speed again.
// RULE14 - Jog motion only while servo is on.
// RULE15 - Writing 406 to special_function_key forces outputs; 400 returns normal.
// RULE16 - Each forced_output_value bit drives one output line, bit 0 first.
// RULE17 - Forced value cleared at power-up; outputs resume configured functions.
// RULE18 - Forced control only while servo is off.
// RULE19 - Forced value hex view blanks the fifth digit.
// RULE20 - Input status view: one bit per input, nine lines, hex, 1 means on.
// RULE21 - Output status view: one bit per output, six lines, hex, 1 means on.
// RULE22 - Each key debounced, giving one-cycle press event and held level.
// RULE23 - SHIFT held two seconds toggles sign; refused if result leaves range.
package panel_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int DEB_TIME_MS = 20;
   localparam int DEB_CYC = DEB_TIME_MS * (CLK_HZ / 1000);
   localparam int HOLD_TIME_S = 2;
   localparam int HOLD_CYC = HOLD_TIME_S * CLK_HZ;
   localparam int BLINK_TIME_MS = 250;
   localparam int BLINK_CYC = BLINK_TIME_MS * (CLK_HZ / 1000);

   localparam int KEY_UP = 0;
   localparam int KEY_DOWN = 1;
   localparam int KEY_SHIFT = 2;
   localparam int KEY_SET = 3;
   localparam int KEY_MODE = 4;
   localparam int KEY_COUNT = 5;

   localparam logic [4:0] MON_INERTIA = 5'h0F;
   localparam logic [4:0] MON_RESON = 5'h11;
   localparam logic [4:0] MON_ENC_IDX = 5'h12;
   localparam logic [4:0] MON_LAST = 5'h12;
   localparam logic [4:0] MON_RESET = 5'h00;
   localparam logic [31:0] ENC_LIM = 32'h0000_1388;

   localparam logic [15:0] SFK_FORCE = 16'h0196;
   localparam logic [15:0] SFK_NORMAL = 16'h0190;

   localparam logic [15:0] JOG_DEFAULT = 16'h0014;
   localparam logic [16:0] JOG_MAX = 17'h0_1388;
   localparam logic [16:0] JOG_MIN = 17'h1_EC78;
   localparam logic [1:0] CUR_LAST = 2'h3;

   localparam int FLT_ENTRIES = 5;
   localparam logic [2:0] FLT_LAST = 3'h4;
   localparam int DI_LINES = 9;
   localparam int DO_LINES = 6;

   localparam logic [4:0] SYM_ZERO = 5'h00;
   localparam logic [4:0] SYM_F = 5'h0F;
   localparam logic [4:0] SYM_BLANK = 5'h10;
   localparam logic [4:0] SYM_H = 5'h11;
   localparam logic [4:0] SYM_L = 5'h12;
   localparam logic [4:0] SYM_J = 5'h13;
   localparam logic [4:0] SYM_G = 5'h14;
   localparam int DP_HIGH = 1;
   localparam int DP_SIGN_A = 4;
   localparam int DP_SIGN_B = 3;

   typedef enum logic [8:0] {
      ST_MON = 9'h001,
      ST_FLT_SEL = 9'h002,
      ST_FLT_CODE = 9'h004,
      ST_JOG_ENT = 9'h008,
      ST_JOG_EDIT = 9'h010,
      ST_JOG_RUN = 9'h020,
      ST_FORCE = 9'h040,
      ST_DI = 9'h080,
      ST_DO = 9'h100
   } page_t;
endpackage

// ### verilog/key_debounce.sv
// One panel key: pin synchroniser, debounce filter, press event.
// Assumes the key pin is asynchronous and active high when pressed.
`timescale 1ns/1ps
`default_nettype none
module key_debounce #(
   parameter int DEB_CYC = panel_pkg::DEB_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic key_raw,
   output logic key_level,
   output logic key_press
);
   localparam int CW = $clog2(DEB_CYC + 1);
   logic sync1_q, sync2_q, level_q, press_q;
   logic [CW-1:0] cnt_q;
   wire differ = sync2_q != level_q;
   wire settled = cnt_q == CW'(DEB_CYC - 1);

   generate
      if (DEB_CYC < 1) begin : g_chk
         $error("key_debounce: DEB_CYC must be at least 1");
      end
   endgenerate

   // Level must differ for the whole window before it is taken [RULE22]
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         level_q <= 1'b0;
         press_q <= 1'b0;
         cnt_q <= '0;
      end else if (ce) begin
         sync1_q <= key_raw;
         sync2_q <= sync1_q;
         press_q <= differ & settled & sync2_q;
         if (!differ) cnt_q <= '0;
         else if (settled) begin
            level_q <= sync2_q;
            cnt_q <= '0;
         end else cnt_q <= cnt_q + CW'(1);
      end
   end

   assign key_level = level_q;
   assign key_press = press_q & ce;
endmodule
`default_nettype wire

// ### verilog/panel_fmt.sv
// Value-to-digit formatter for the five-digit display.
// Purely combinational; the caller registers its outputs.
`timescale 1ns/1ps
`default_nettype none
module panel_fmt (
   input wire logic [31:0] value,
   input wire logic is32,
   input wire logic hex,
   input wire logic high,
   input wire logic signd,
   output logic [24:0] digits,
   output logic [4:0] dp
);
   logic neg;
   logic [31:0] mag;
   logic [39:0] bcd;
   always_comb begin
      // Hex views never carry a sign [RULE8]
      neg = signd & ~hex & (is32 ? value[31] : value[15]);
      if (is32) mag = neg ? (~value + 32'h0000_0001) : value;
      else mag = {16'h0000, neg ? (~value[15:0] + 16'h0001) : value[15:0]};
      bcd = '0;
      for (int i = 31; i >= 0; i--) begin
         for (int d = 0; d < 10; d++) begin
            if (bcd[d*4 +: 4] > 4'h4) bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
         end
         bcd = {bcd[38:0], mag[i]};
      end
      digits = '0;
      dp = '0;
      if (hex && is32) begin
         // Marker then four hex digits of the chosen half [RULE7]
         digits[24:20] = high ? panel_pkg::SYM_H : panel_pkg::SYM_L;
         for (int d = 0; d < 4; d++)
            digits[d*5 +: 5] = {1'b0, high ? value[16+d*4 +: 4] : value[d*4 +: 4]};
      end else if (hex) begin
         // Four hex digits, fifth blanked, no prefix [RULE5] [RULE19]
         digits[24:20] = panel_pkg::SYM_BLANK;
         for (int d = 0; d < 4; d++) digits[d*5 +: 5] = {1'b0, value[d*4 +: 4]};
      end else begin
         // Leading zeros kept; high view of a 32-bit value is marked [RULE5] [RULE6]
         for (int d = 0; d < 5; d++)
            digits[d*5 +: 5] = {1'b0, (is32 && high) ? bcd[20+d*4 +: 4] : bcd[d*4 +: 4]};
         if (is32 && high) dp[panel_pkg::DP_HIGH] = 1'b1;
         if (neg) begin
            dp[panel_pkg::DP_SIGN_A] = 1'b1; // [RULE8]
            dp[panel_pkg::DP_SIGN_B] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/panel_monitor.sv
// Front-panel top: page control, monitor select, jog, forced outputs, diagnosis.
// Assumes keys, index pulse and input lines are asynchronous pins; all else is
// on mclk. Display codes: 0-F digits, then blank, h, L, J, G symbols.
`timescale 1ns/1ps
`default_nettype none
module panel_monitor #(
   parameter int DEB_CYC = panel_pkg::DEB_CYC,
   parameter int HOLD_CYC = panel_pkg::HOLD_CYC,
   parameter int BLINK_CYC = panel_pkg::BLINK_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [4:0] key_raw,
   input wire logic mon_sel_wr,
   input wire logic [4:0] mon_sel_wdata,
   input wire logic [31:0] general_monitor,
   input wire logic [15:0] inertia_ratio_x10,
   input wire logic [15:0] reson_freq1,
   input wire logic [15:0] reson_freq2,
   input wire logic [31:0] encoder_count,
   input wire logic index_pulse,
   input wire logic [79:0] fault_history,
   input wire logic servo_on,
   input wire logic sfk_wr,
   input wire logic [15:0] sfk_wdata,
   input wire logic fov_wr,
   input wire logic [5:0] fov_wdata,
   input wire logic [8:0] digital_input_line,
   input wire logic [5:0] do_function,
   output logic [4:0] monitor_item_select,
   output logic [24:0] seg_digits,
   output logic [4:0] seg_dp,
   output logic [15:0] jog_speed,
   output logic jog_ccw,
   output logic jog_cw,
   output logic forced_mode,
   output logic [5:0] do_line
);
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam int BW = $clog2(BLINK_CYC + 1);

   generate
      if (HOLD_CYC < 2 || BLINK_CYC < 1) begin : g_chk
         $error("panel_monitor: HOLD_CYC or BLINK_CYC too small");
      end
   endgenerate

   // Key conditioning
   logic [4:0] key_level, key_press;
   genvar k;
   generate
      for (k = 0; k < panel_pkg::KEY_COUNT; k++) begin : g_key
         key_debounce #(.DEB_CYC(DEB_CYC)) u_key (
            .mclk(mclk),
            .reset(reset),
            .ce(ce),
            .key_raw(key_raw[k]),
            .key_level(key_level[k]),
            .key_press(key_press[k])
         );
      end
   endgenerate
   wire up_p = key_press[panel_pkg::KEY_UP];
   wire dn_p = key_press[panel_pkg::KEY_DOWN];
   wire sh_p = key_press[panel_pkg::KEY_SHIFT];
   wire set_p = key_press[panel_pkg::KEY_SET];
   wire mode_p = key_press[panel_pkg::KEY_MODE];

   // Pin synchronisers
   logic [8:0] di_s1_q, di_s2_q;
   logic idx_s1_q, idx_s2_q, idx_s3_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         di_s1_q <= '0;
         di_s2_q <= '0;
         idx_s1_q <= 1'b0;
         idx_s2_q <= 1'b0;
         idx_s3_q <= 1'b0;
      end else if (ce) begin
         di_s1_q <= digital_input_line;
         di_s2_q <= di_s1_q;
         idx_s1_q <= index_pulse;
         idx_s2_q <= idx_s1_q;
         idx_s3_q <= idx_s2_q;
      end
   end
   wire idx_rise = idx_s2_q & ~idx_s3_q;

   // State
   panel_pkg::page_t page_q, page_d;
   logic [4:0] sel_q;
   logic mon_hex_q, mon_high_q;
   logic [2:0] flt_idx_q;
   logic [15:0] jog_q;
   logic [1:0] cur_q;
   logic [HW-1:0] hold_q;
   logic [BW-1:0] blink_cnt_q;
   logic blink_q;
   logic force_q;
   logic [5:0] fov_q;
   logic [31:0] idx_lat_q;

   always_comb begin
      page_d = page_q;
      case (page_q)
         panel_pkg::ST_MON: if (mode_p) page_d = panel_pkg::ST_FLT_SEL;
         panel_pkg::ST_FLT_SEL: begin
            if (set_p) page_d = panel_pkg::ST_FLT_CODE; // [RULE10]
            else if (mode_p) page_d = panel_pkg::ST_JOG_ENT;
         end
         panel_pkg::ST_FLT_CODE: if (set_p || mode_p) page_d = panel_pkg::ST_FLT_SEL;
         panel_pkg::ST_JOG_ENT: begin
            if (set_p) page_d = panel_pkg::ST_JOG_EDIT; // [RULE11]
            else if (mode_p) page_d = panel_pkg::ST_FORCE;
         end
         panel_pkg::ST_JOG_EDIT: begin
            if (set_p) page_d = panel_pkg::ST_JOG_RUN; // [RULE12]
            else if (mode_p) page_d = panel_pkg::ST_JOG_ENT;
         end
         panel_pkg::ST_JOG_RUN: if (mode_p) page_d = panel_pkg::ST_JOG_ENT; // [RULE13]
         panel_pkg::ST_FORCE: if (mode_p) page_d = panel_pkg::ST_DI;
         panel_pkg::ST_DI: if (mode_p) page_d = panel_pkg::ST_DO;
         panel_pkg::ST_DO: if (mode_p) page_d = panel_pkg::ST_MON;
         default: page_d = panel_pkg::ST_MON;
      endcase
   end

   wire in_mon = page_q == panel_pkg::ST_MON;
   wire in_fsel = page_q == panel_pkg::ST_FLT_SEL;
   wire in_edit = page_q == panel_pkg::ST_JOG_EDIT;
   wire in_run = page_q == panel_pkg::ST_JOG_RUN;
   wire in_force = page_q == panel_pkg::ST_FORCE;

   // Monitor item stepping with wrap
   wire [4:0] sel_up = (sel_q == panel_pkg::MON_LAST) ? 5'h00 : sel_q + 5'h01;
   wire [4:0] sel_dn = (sel_q == 5'h00) ? panel_pkg::MON_LAST : sel_q - 5'h01;
   wire sel_ok = mon_sel_wdata <= panel_pkg::MON_LAST;

   // Jog speed edit arithmetic, saturating at the limits
   logic [16:0] step;
   always_comb begin
      case (cur_q)
         2'h0: step = 17'h0_0001;
         2'h1: step = 17'h0_000A;
         2'h2: step = 17'h0_0064;
         default: step = 17'h0_03E8;
      endcase
   end
   wire signed [16:0] sp = {jog_q[15], jog_q};
   wire signed [16:0] sp_up = sp + $signed(step);
   wire signed [16:0] sp_dn = sp - $signed(step);
   wire signed [16:0] sp_neg = 17'h0_0000 - sp;
   wire signed [16:0] lim_hi = $signed(panel_pkg::JOG_MAX);
   wire signed [16:0] lim_lo = $signed(panel_pkg::JOG_MIN);
   wire [15:0] jog_up = (sp_up > lim_hi) ? lim_hi[15:0] : sp_up[15:0];
   wire [15:0] jog_dn = (sp_dn < lim_lo) ? lim_lo[15:0] : sp_dn[15:0];
   wire neg_ok = (sp_neg <= lim_hi) && (sp_neg >= lim_lo);
   wire hold_fire = hold_q == HW'(HOLD_CYC - 1);

   // Forced control only with servo off [RULE18]
   wire sfk_force = sfk_wr && (sfk_wdata == panel_pkg::SFK_FORCE) && !servo_on;
   wire sfk_norm = sfk_wr && (sfk_wdata == panel_pkg::SFK_NORMAL);
   wire fov_key_ok = in_force && force_q && !servo_on;

   always_ff @(posedge mclk) begin
      if (reset) begin
         page_q <= panel_pkg::ST_MON;
         sel_q <= panel_pkg::MON_RESET;
         mon_hex_q <= 1'b0;
         mon_high_q <= 1'b0;
         flt_idx_q <= 3'h0;
      end else if (ce) begin
         page_q <= page_d;
         // Direct write takes priority over a key step [RULE1]
         if (mon_sel_wr && sel_ok) sel_q <= mon_sel_wdata;
         else if (in_mon && up_p) sel_q <= sel_up;
         else if (in_mon && dn_p) sel_q <= sel_dn;
         // Radix and half switch freely on monitor values [RULE9]
         if (in_mon && set_p) mon_hex_q <= ~mon_hex_q;
         if (in_mon && sh_p) mon_high_q <= ~mon_high_q;
         if (in_fsel && up_p) flt_idx_q <= (flt_idx_q == panel_pkg::FLT_LAST) ? 3'h0
                                           : flt_idx_q + 3'h1;
         else if (in_fsel && dn_p) flt_idx_q <= (flt_idx_q == 3'h0) ? panel_pkg::FLT_LAST
                                                 : flt_idx_q - 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         jog_q <= panel_pkg::JOG_DEFAULT;
         cur_q <= 2'h0;
         hold_q <= '0;
      end else if (ce) begin
         // UP/DOWN adjust the cursor digit, SHIFT moves it [RULE11]
         if (in_edit && up_p) jog_q <= jog_up;
         else if (in_edit && dn_p) jog_q <= jog_dn;
         else if (in_edit && hold_fire && neg_ok) jog_q <= sp_neg[15:0]; // [RULE23]
         if (in_edit && sh_p) cur_q <= (cur_q == panel_pkg::CUR_LAST) ? 2'h0 : cur_q + 2'h1;
         // Counts once per hold; stops at the top until SHIFT is released [RULE23]
         if (!in_edit || !key_level[panel_pkg::KEY_SHIFT]) hold_q <= '0;
         else if (hold_q != HW'(HOLD_CYC)) hold_q <= hold_q + HW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
      end else if (ce) begin
         if (blink_cnt_q == BW'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
         end else blink_cnt_q <= blink_cnt_q + BW'(1);
      end
   end

   // Reset stands for power-up: forced state and value are dropped [RULE17]
   always_ff @(posedge mclk) begin
      if (reset) begin
         force_q <= 1'b0;
         fov_q <= '0;
      end else if (ce) begin
         if (sfk_force) force_q <= 1'b1; // [RULE15]
         else if (sfk_norm) force_q <= 1'b0;
         if (fov_wr && force_q && !servo_on) fov_q <= fov_wdata;
         else if (fov_key_ok && up_p) fov_q <= fov_q + 6'h01;
         else if (fov_key_ok && dn_p) fov_q <= fov_q - 6'h01;
      end
   end

   // Index pulse marks the zero of the relative position [RULE4]
   always_ff @(posedge mclk) begin
      if (reset) idx_lat_q <= '0;
      else if (ce && idx_rise) idx_lat_q <= encoder_count;
   end
   wire signed [31:0] enc_rel = encoder_count - idx_lat_q;
   wire signed [31:0] enc_hi = $signed(panel_pkg::ENC_LIM);
   wire signed [31:0] enc_lo = 32'sh0 - $signed(panel_pkg::ENC_LIM);
   wire [31:0] enc_clamp = (enc_rel > enc_hi) ? enc_hi
                           : (enc_rel < enc_lo) ? enc_lo : enc_rel; // [RULE4]

   // Monitored quantity mux [RULE1]
   wire [31:0] mon_val =
      (sel_q == panel_pkg::MON_INERTIA) ? {16'h0000, inertia_ratio_x10} : // [RULE2]
      (sel_q == panel_pkg::MON_RESON) ? {reson_freq2, reson_freq1} : // [RULE3]
      (sel_q == panel_pkg::MON_ENC_IDX) ? enc_clamp : general_monitor;

   // Output lines: forced only in forced mode with servo off [RULE16] [RULE18]
   wire force_act = force_q && !servo_on;
   wire [5:0] do_now = force_act ? fov_q : do_function;

   // Per-page display source
   wire [15:0] flt_code = fault_history[flt_idx_q*16 +: 16];
   logic [31:0] f_val;
   logic f_is32, f_hex, f_signd;
   always_comb begin
      f_val = 32'h0000_0000;
      f_is32 = 1'b0;
      f_hex = 1'b0;
      f_signd = 1'b0;
      case (page_q)
         panel_pkg::ST_MON: begin
            f_val = mon_val;
            f_is32 = 1'b1;
            f_hex = mon_hex_q;
            f_signd = 1'b1;
         end
         panel_pkg::ST_FLT_CODE: f_val = {16'h0000, flt_code}; // [RULE10]
         panel_pkg::ST_JOG_EDIT: begin
            f_val = {16'h0000, jog_q};
            f_signd = 1'b1;
         end
         panel_pkg::ST_FORCE: begin
            f_val = {26'h000_0000, fov_q};
            f_hex = 1'b1; // [RULE19]
         end
         panel_pkg::ST_DI: begin
            f_val = {23'h00_0000, di_s2_q}; // [RULE20]
            f_hex = 1'b1;
         end
         panel_pkg::ST_DO: begin
            f_val = {26'h000_0000, do_now}; // [RULE21]
            f_hex = 1'b1;
         end
         default: f_val = 32'h0000_0000;
      endcase
   end

   logic [24:0] f_digits;
   logic [4:0] f_dp;
   panel_fmt u_fmt (
      .value(f_val),
      .is32(f_is32),
      .hex(f_hex),
      .high(mon_high_q),
      .signd(f_signd),
      .digits(f_digits),
      .dp(f_dp)
   );

   // Prompts replace the formatted value on menu pages
   wire [24:0] p_fsel = {panel_pkg::SYM_F, panel_pkg::SYM_BLANK, panel_pkg::SYM_BLANK,
                         panel_pkg::SYM_BLANK, 2'b00, flt_idx_q};
   wire [24:0] p_jent = {panel_pkg::SYM_J, panel_pkg::SYM_BLANK, panel_pkg::SYM_BLANK,
                         panel_pkg::SYM_BLANK, panel_pkg::SYM_BLANK};
   wire [24:0] p_jrun = {panel_pkg::SYM_BLANK, panel_pkg::SYM_BLANK, panel_pkg::SYM_J,
                         panel_pkg::SYM_ZERO, panel_pkg::SYM_G}; // [RULE12]
   logic [24:0] edit_digits;
   always_comb begin
      edit_digits = f_digits;
      // Blink off-phase blanks the cursor digit [RULE11]
      if (blink_q) edit_digits[cur_q*5 +: 5] = panel_pkg::SYM_BLANK;
   end
   wire [24:0] show_digits =
      in_fsel ? p_fsel :
      (page_q == panel_pkg::ST_JOG_ENT) ? p_jent :
      in_run ? p_jrun :
      in_edit ? edit_digits : f_digits;
   wire prompt = in_fsel || in_run || (page_q == panel_pkg::ST_JOG_ENT);

   // Rotation only while a key is held, servo on, and jog page active [RULE12] [RULE14]
   wire run_ok = in_run && servo_on;
   wire ccw_d = run_ok && key_level[panel_pkg::KEY_UP];
   wire cw_d = run_ok && key_level[panel_pkg::KEY_DOWN] && !key_level[panel_pkg::KEY_UP];

   logic [24:0] seg_digits_q;
   logic [4:0] seg_dp_q;
   logic ccw_q, cw_q;
   logic [5:0] do_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         seg_digits_q <= {5{panel_pkg::SYM_BLANK}};
         seg_dp_q <= '0;
         ccw_q <= 1'b0;
         cw_q <= 1'b0;
         do_q <= '0;
      end else if (ce) begin
         seg_digits_q <= show_digits;
         seg_dp_q <= prompt ? 5'h00 : f_dp;
         ccw_q <= ccw_d;
         cw_q <= cw_d;
         do_q <= do_now;
      end
   end

   assign monitor_item_select = sel_q;
   assign seg_digits = seg_digits_q;
   assign seg_dp = seg_dp_q;
   assign jog_speed = jog_q;
   assign jog_ccw = ccw_q;
   assign jog_cw = cw_q;
   assign forced_mode = force_q;
   assign do_line = do_q;
endmodule
`default_nettype wire

// ### tb/panel_monitor_asserts.sv
// Port checker for the front-panel top.
// Assumes one clock domain, mclk, with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module panel_monitor_asserts (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic mon_sel_wr,
   input wire logic [4:0] mon_sel_wdata,
   input wire logic servo_on,
   input wire logic sfk_wr,
   input wire logic [15:0] sfk_wdata,
   input wire logic [5:0] do_function,
   input wire logic [4:0] monitor_item_select,
   input wire logic [4:0] seg_dp,
   input wire logic [15:0] jog_speed,
   input wire logic jog_ccw,
   input wire logic jog_cw,
   input wire logic forced_mode,
   input wire logic [5:0] do_line
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   AST_SEL_RANGE: assert property (monitor_item_select <= 5'h12) else $error("bad code");
   AST_SEL_WR: assert property (ce && mon_sel_wr && mon_sel_wdata <= 5'h12
      |=> monitor_item_select == $past(mon_sel_wdata)) else $error("monitor code write lost");
   AST_NORMAL_DO: assert property (!$past(reset) && $past(ce)
      && ($past(servo_on) || !$past(forced_mode) && !forced_mode)
      |-> do_line == $past(do_function)) else $error("outputs not function driven");
   AST_RESET_VALS: assert property (disable iff (1'b0) $past(reset) && $past(ce)
      |-> jog_speed == 16'h0014 && !forced_mode && do_line == 6'h00)
      else $error("wrong values after reset");
   AST_JOG_SERVO: assert property (jog_ccw || jog_cw |-> $past(servo_on))
      else $error("jog while drive disabled");
   AST_JOG_ONE: assert property (!(jog_ccw && jog_cw)) else $error("both jog directions");
   AST_FORCE_ON: assert property ($rose(forced_mode)
      |-> $past(sfk_wr && sfk_wdata == 16'h0196 && !servo_on)) else $error("forced mode unasked");
   AST_FORCE_OFF: assert property ($fell(forced_mode)
      |-> $past(reset) || $past(sfk_wr && sfk_wdata == 16'h0190)) else $error("forced mode lost");
   AST_SIGN_PAIR: assert property (seg_dp[4] == seg_dp[3]) else $error("sign split");
   AST_JOG_RANGE: assert property (jog_speed[15] ? -jog_speed <= 16'h1388
      : jog_speed <= 16'h1388) else $error("jog speed out of range");
endmodule
bind panel_monitor panel_monitor_asserts chk (.mclk, .reset, .ce, .mon_sel_wr, .mon_sel_wdata,
   .servo_on, .sfk_wr, .sfk_wdata, .do_function, .monitor_item_select, .seg_dp, .jog_speed,
   .jog_ccw, .jog_cw, .forced_mode, .do_line);
`default_nettype wire

// ### tb/panel_keypad.sv
// Keypad model: clean key levels, held long enough to pass debounce.
// Assumes the bench calls its tasks; keys move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module panel_keypad (
   input wire logic mclk,
   output logic [4:0] key_raw
);
   initial key_raw = 5'h00;
   task automatic hold(input int k, input logic on);
      @(negedge mclk);
      key_raw[k] = on;
   endtask
   task automatic tap(input int k);
      hold(k, 1'b1);
      repeat (12) @(negedge mclk);
      hold(k, 1'b0);
      repeat (12) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the front-panel top.
// Assumes short debounce, hold and blink counts; no seed, fixed tables.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {logic [4:0] sel; logic [31:0] val; logic [29:0] exp;} row_t;
   logic mclk, reset, ce, mon_sel_wr, index_pulse, servo_on, sfk_wr, fov_wr, jog_ccw, jog_cw;
   logic [4:0] mon_sel_wdata, monitor_item_select, seg_dp, key_raw;
   logic [31:0] general_monitor, encoder_count;
   logic [15:0] inertia_ratio_x10, reson_freq1, reson_freq2, sfk_wdata, jog_speed;
   logic [79:0] fault_history;
   logic [5:0] fov_wdata, do_function, do_line;
   logic [8:0] digital_input_line;
   logic [24:0] seg_digits;
   logic forced_mode;
   int bad_count, checks_done;
   row_t rows [6];
   panel_keypad kp (.mclk, .key_raw);
   panel_monitor #(.DEB_CYC(4), .HOLD_CYC(40), .BLINK_CYC(8)) uut (.mclk, .reset, .ce,
      .key_raw, .mon_sel_wr, .mon_sel_wdata, .general_monitor, .inertia_ratio_x10,
      .reson_freq1, .reson_freq2, .encoder_count, .index_pulse, .fault_history, .servo_on,
      .sfk_wr, .sfk_wdata, .fov_wr, .fov_wdata, .digital_input_line, .do_function,
      .monitor_item_select, .seg_digits, .seg_dp, .jog_speed, .jog_ccw, .jog_cw,
      .forced_mode, .do_line);
   always #50 mclk = ~mclk;
   function automatic logic [24:0] d5(input logic [4:0] a, b, c, d, e);
      return {a, b, c, d, e};
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic seg(input logic [29:0] exp);
      cmp({seg_dp, seg_digits}, exp);
   endtask
   task automatic wr(input int w, input logic [15:0] v);
      @(negedge mclk);
      {mon_sel_wr, sfk_wr, fov_wr} = 3'h4 >> w;
      {mon_sel_wdata, sfk_wdata, fov_wdata} = {v[4:0], v, v[5:0]};
      @(negedge mclk);
      {mon_sel_wr, sfk_wr, fov_wr} = 3'h0;
      repeat (3) @(negedge mclk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      finish_test;
   end
   initial begin
      {digital_input_line, do_function, mclk, reset, ce, index_pulse, servo_on} = 20'hF07ED;
      {mon_sel_wr, sfk_wr, fov_wr, mon_sel_wdata, sfk_wdata, fov_wdata} = '0;
      {general_monitor, encoder_count, inertia_ratio_x10, reson_freq1, reson_freq2} = '0;
      fault_history = 80'h0309;
      rows[0] = '{5'h00, 32'h0000_04D2, {5'h00, d5(0, 1, 2, 3, 4)}};
      rows[1] = '{5'h00, 32'hFFFF_CFC7, {5'h18, d5(1, 2, 3, 4, 5)}};
      rows[2] = '{5'h0F, 32'h0000_0082, {5'h00, d5(0, 0, 1, 3, 0)}};
      rows[3] = '{5'h11, 32'h00C8_0064, {5'h00, d5(0, 7, 3, 0, 0)}};
      rows[4] = '{5'h12, 32'h0000_2328, {5'h00, d5(0, 5, 0, 0, 0)}};
      rows[5] = '{5'h12, 32'hFFFF_E4A8, {5'h18, d5(0, 5, 0, 0, 0)}};
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      foreach (rows[i]) begin
         {general_monitor, encoder_count} = {2{rows[i].val}};
         {inertia_ratio_x10, reson_freq2, reson_freq1} = {rows[i].val[15:0], rows[i].val};
         wr(0, 16'(rows[i].sel));
         cmp(32'(monitor_item_select), 32'(rows[i].sel));
         seg(rows[i].exp);
      end
      index_pulse = 1'b1;
      repeat (6) @(negedge mclk);
      seg({5'h00, d5(0, 0, 0, 0, 0)});
      wr(0, 16'h0000);
      general_monitor = 32'h4996_02D2;
      kp.tap(2);
      seg({5'h02, d5(1, 2, 3, 4, 5)});
      general_monitor = 32'h1234_5678;
      kp.tap(3);
      seg({5'h00, d5(5'h11, 1, 2, 3, 4)});
      kp.tap(2);
      seg({5'h00, d5(5'h12, 5, 6, 7, 8)});
      general_monitor = 32'hFFFF_CFC7;
      repeat (3) @(negedge mclk);
      seg({5'h00, d5(5'h12, 5'h0C, 5'h0F, 5'h0C, 7)});
      kp.tap(4);
      kp.tap(3);
      seg({5'h00, d5(0, 0, 7, 7, 7)});
      kp.tap(3);
      kp.tap(4);
      seg({5'h00, d5(5'h13, 5'h10, 5'h10, 5'h10, 5'h10)});
      kp.tap(3);
      kp.tap(0);
      cmp(32'(jog_speed), 32'h15);
      kp.tap(3);
      for (int s = 1; s >= 0; s--) begin
         servo_on = s[0];
         kp.hold(1 - s, 1'b1);
         repeat (12) @(negedge mclk);
         cmp({jog_ccw, jog_cw}, {s[0], 1'b0});
         kp.hold(1 - s, 1'b0);
         repeat (12) @(negedge mclk);
         cmp({jog_ccw, jog_cw}, 2'h0);
      end
      kp.tap(4);
      seg({5'h00, d5(5'h13, 5'h10, 5'h10, 5'h10, 5'h10)});
      kp.tap(4);
      kp.tap(4);
      seg({5'h00, d5(5'h10, 0, 1, 5'h0E, 0)});
      kp.tap(4);
      seg({5'h00, d5(5'h10, 0, 0, 3, 5'h0F)});
      servo_on = 1'b1;
      wr(1, 16'h0196);
      cmp(32'(forced_mode), 32'h0);
      servo_on = 1'b0;
      wr(1, 16'h0196);
      wr(2, 16'h0002);
      cmp(32'(do_line), 32'h02);
      wr(2, 16'h0007);
      cmp(32'(do_line), 32'h07);
      servo_on = 1'b1;
      do_function = 6'h15;
      repeat (3) @(negedge mclk);
      cmp(32'(do_line), 32'h15);
      servo_on = 1'b0;
      wr(1, 16'h0190);
      cmp({forced_mode, do_line}, 7'h15);
      ce = 1'b0;
      wr(1, 16'h0196);
      ce = 1'b1;
      cmp(32'(forced_mode), 32'h0);
      wr(1, 16'h0196);
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      repeat (3) @(negedge mclk);
      cmp({forced_mode, do_line}, 7'h15);
      finish_test;
   end
endmodule
`default_nettype wire
